// ---- app_reg_consts.vh ----
// constants for the application register file: indices, field positions, reset values
// assumes inclusion by bare name from the design files
`ifndef APP_REG_CONSTS_VH
`define APP_REG_CONSTS_VH

`define IDX_KMSG_LAST       7'h07
`define IDX_STACK_CFG       7'h10
`define IDX_STACK_BACKING   7'h11
`define IDX_STACK_SPILL     7'h12
`define IDX_STACK_TOKEN     7'h13
`define IDX_LEG_FLT_CTRL    7'h15
`define IDX_LEG_FLAGS       7'h18
`define IDX_LEG_CODE_DESC   7'h19
`define IDX_LEG_STACK_DESC  7'h1A
`define IDX_LEG_COMB_CTRL   7'h1B
`define IDX_LEG_FLT_STAT    7'h1C
`define IDX_LEG_FLT_INSTR   7'h1D
`define IDX_LEG_FLT_DATA    7'h1E
`define IDX_CMPXCHG_VAL     7'h20
`define IDX_USER_TOKEN      7'h24
`define IDX_FLT_STAT_CTRL   7'h28
`define IDX_INTERVAL_TIMER  7'h2C
`define IDX_IGN_LO_FIRST    7'h30
`define IDX_IGN_LO_LAST     7'h3F
`define IDX_PREV_CALL       7'h40
`define IDX_LOOP_COUNTER    7'h41
`define IDX_EPILOG_COUNTER  7'h42
`define IDX_IGN_HI_FIRST    7'h70

`define CFG_MODE_LSB        0
`define CFG_PRIV_LSB        2
`define CFG_ORDER_BIT       4
`define CFG_LOAD_LSB        16
`define CFG_LOAD_MSB        29
`define CFG_WRITE_MASK      64'h000000003FFF001F
`define TOKEN_WRITE_MASK    64'h7FFFFFFFFFFFFFFF
`define LEG_FLAGS_PRIV_MASK 64'h0000000000003000
`define EPILOG_WIDTH        6

`define UNIT_MEM            1'b0
`define UNIT_INT            1'b1

`define ERR_NONE            2'h0
`define ERR_PRIV            2'h1
`define ERR_ILLEGAL         2'h2

`define RESET_WORD          64'h0000000000000000

`endif

// ---- app_reg_mem.v ----
// small storage array for the plain read/write application registers
// assumes one writer per cycle; read data registered, one cycle late
`timescale 1ns/1ps
module app_reg_mem #(
  parameter WIDTH = 64,
  parameter DEPTH = 16,
  parameter AW    = 4
) (
  input  wire             i_sys_clk,
  input  wire             i_srst,
  input  wire             i_we,
  input  wire [AW-1:0]    i_waddr,
  input  wire [WIDTH-1:0] i_wdata,
  input  wire [AW-1:0]    i_raddr,
  output reg  [WIDTH-1:0] o_rdata
);

  reg [WIDTH-1:0] mem_q [0:DEPTH-1];
  integer         k;

  // cleared on reset so reads never show unknown values
  always @(posedge i_sys_clk)
  begin
    if (i_srst)
    begin
      for (k = 0; k < DEPTH; k = k + 1)
        mem_q[k] <= {WIDTH{1'b0}};
      o_rdata <= {WIDTH{1'b0}};
    end
    else
    begin
      if (i_we)
        mem_q[i_waddr] <= i_wdata;
      o_rdata <= mem_q[i_raddr];
    end
  end

endmodule

// ---- stack_cfg_decode.v ----
// decodes the stack engine configuration word into its operating controls
// assumes the word already has reserved bits cleared
`timescale 1ns/1ps
`include "app_reg_consts.vh"
module stack_cfg_decode (
  input  wire [63:0] i_cfg,
  output wire        o_eager_load,
  output wire        o_eager_store,
  output wire [1:0]  o_stack_privilege_field,
  output wire        o_stack_byte_order,
  output wire [13:0] o_load_distance
);

  // mode bit 1 = eager loads, bit 0 = eager stores
  assign o_eager_load            = i_cfg[`CFG_MODE_LSB+1];
  assign o_eager_store           = i_cfg[`CFG_MODE_LSB];
  assign o_stack_privilege_field = i_cfg[`CFG_PRIV_LSB+1:`CFG_PRIV_LSB];
  assign o_stack_byte_order      = i_cfg[`CFG_ORDER_BIT];
  assign o_load_distance         = i_cfg[`CFG_LOAD_MSB:`CFG_LOAD_LSB];

endmodule

// ---- application_register_file.v ----
// application register file: index decode, privilege and unit checks, storage
// assumes execution units issue one access per cycle, reads answered next cycle
//
// Behaviour
// - stack config at 16, interval timer at 44, epilog count at 66.
// - backing pointer at 17 is read-only to register writes.
// - kernel message or combined control write at nonzero privilege faults.
// - indices 0-47 memory unit only, 64-111 integer unit only.
// - ranges 48-63 and 112-127 are ignored, hold no storage.
// - some legacy flags fields silently not written at nonzero privilege.
// - eight 64-bit kernel message registers, readable always.
// - kernel message 0-2 hold extra legacy state during legacy execution.
// - stack config is 64 bits, fields drive stack engine controls.
// - config privilege field never set more privileged than current.
// - mode bit 1 eager loads, bit 0 eager stores.
// - stack engine accesses use privilege in config bits 3:2.
// - config bit 4 selects stack engine byte order.
// - load distance held in config bits 29:16 for synchronising load.
// - token collection bit 63 reads zero, writes to it ignored.
// - epilog counter is six bits wide.
`timescale 1ns/1ps
`include "app_reg_consts.vh"
module application_register_file #(
  parameter EPILOG_W = `EPILOG_WIDTH
) (
  input  wire                i_sys_clk,
  input  wire                i_srst,
  input  wire                i_req_valid,
  input  wire                i_req_write,
  input  wire                i_req_unit,
  input  wire [6:0]          i_req_index,
  input  wire [63:0]         i_req_wdata,
  input  wire [1:0]          i_cur_priv,
  input  wire                i_legacy_mode,
  input  wire                i_legacy_kmsg_we,
  input  wire [1:0]          i_legacy_kmsg_sel,
  input  wire [63:0]         i_legacy_kmsg_wdata,
  input  wire                i_backing_we,
  input  wire [63:0]         i_backing_wdata,
  input  wire                i_timer_we,
  input  wire [63:0]         i_timer_wdata,
  input  wire                i_epilog_we,
  input  wire [EPILOG_W-1:0] i_epilog_wdata,
  output reg                 o_rsp_valid,
  output reg  [63:0]         o_rsp_rdata,
  output reg                 o_priv_fault,
  output reg                 o_illegal_fault,
  output wire                o_eager_load,
  output wire                o_eager_store,
  output wire [1:0]          o_stack_privilege_field,
  output wire                o_stack_byte_order,
  output wire [13:0]         o_load_distance,
  output wire [63:0]         o_stack_spill_pointer,
  output wire [63:0]         o_stack_token_collection,
  output wire [63:0]         o_compare_exchange_value,
  output wire [63:0]         o_loop_counter,
  output wire [EPILOG_W-1:0] o_epilog_counter
);

  // storage array slots for the plain registers
  localparam [3:0] SLOT_FLT_CTRL   = 4'h0;
  localparam [3:0] SLOT_CODE_DESC  = 4'h1;
  localparam [3:0] SLOT_STACK_DESC = 4'h2;
  localparam [3:0] SLOT_FLT_STAT   = 4'h3;
  localparam [3:0] SLOT_FLT_INSTR  = 4'h4;
  localparam [3:0] SLOT_FLT_DATA   = 4'h5;
  localparam [3:0] SLOT_USER_TOKEN = 4'h6;
  localparam [3:0] SLOT_FLT_SCTRL  = 4'h7;
  localparam [3:0] SLOT_PREV_CALL  = 4'h8;
  localparam [3:0] SLOT_NONE       = 4'hF;

  // read source selection, registered with the request
  localparam [2:0] SRC_ZERO = 3'h0;
  localparam [2:0] SRC_MEM  = 3'h1;
  localparam [2:0] SRC_REG  = 3'h2;

  wire [511:0]        kmsg_all;
  reg  [63:0]         cfg_q;
  reg  [63:0]         backing_q;
  reg  [63:0]         spill_q;
  reg  [63:0]         token_q;
  reg  [63:0]         flags_q;
  reg  [63:0]         comb_ctrl_q;
  reg  [63:0]         cmpxchg_q;
  reg  [63:0]         timer_q;
  reg  [63:0]         loop_q;
  reg  [EPILOG_W-1:0] epilog_q;
  reg  [2:0]          src_q;
  reg  [63:0]         reg_rdata_q;
  wire [63:0]         mem_rdata;

  // maps an index onto its storage slot; used by read and write paths
  function [3:0] slot_of;
    input [6:0] idx;
    begin
      case (idx)
        `IDX_LEG_FLT_CTRL:   slot_of = SLOT_FLT_CTRL;
        `IDX_LEG_CODE_DESC:  slot_of = SLOT_CODE_DESC;
        `IDX_LEG_STACK_DESC: slot_of = SLOT_STACK_DESC;
        `IDX_LEG_FLT_STAT:   slot_of = SLOT_FLT_STAT;
        `IDX_LEG_FLT_INSTR:  slot_of = SLOT_FLT_INSTR;
        `IDX_LEG_FLT_DATA:   slot_of = SLOT_FLT_DATA;
        `IDX_USER_TOKEN:     slot_of = SLOT_USER_TOKEN;
        `IDX_FLT_STAT_CTRL:  slot_of = SLOT_FLT_SCTRL;
        `IDX_PREV_CALL:      slot_of = SLOT_PREV_CALL;
        default:             slot_of = SLOT_NONE;
      endcase
    end
  endfunction

  // true for indices that name a real register
  function is_named;
    input [6:0] idx;
    begin
      is_named = (idx <= `IDX_KMSG_LAST) ||
                 (idx >= `IDX_STACK_CFG && idx <= `IDX_STACK_TOKEN) ||
                 (idx == `IDX_LEG_FLAGS) || (idx == `IDX_LEG_COMB_CTRL) ||
                 (idx == `IDX_CMPXCHG_VAL) || (idx == `IDX_INTERVAL_TIMER) ||
                 (idx == `IDX_LOOP_COUNTER) || (idx == `IDX_EPILOG_COUNTER) ||
                 (slot_of(idx) != SLOT_NONE);
    end
  endfunction

  // request classification
  // illegal beats privilege: never both faults at once
  wire ign_idx   = (i_req_index >= `IDX_IGN_LO_FIRST && i_req_index <= `IDX_IGN_LO_LAST) ||
                   (i_req_index >= `IDX_IGN_HI_FIRST);
  wire mem_range = (i_req_index < `IDX_IGN_LO_FIRST);
  wire unit_ok   = ign_idx ||
                   (mem_range ? (i_req_unit == `UNIT_MEM)
                              : (i_req_unit == `UNIT_INT));
  wire legal     = unit_ok && (ign_idx || is_named(i_req_index));
  wire kmsg_idx  = (i_req_index <= `IDX_KMSG_LAST);
  wire priv_reg  = kmsg_idx || (i_req_index == `IDX_LEG_COMB_CTRL);
  wire priv_bad  = i_req_write && priv_reg && (i_cur_priv != 2'b00);
  wire wr_ok     = i_req_valid && i_req_write && legal && !priv_bad && !ign_idx;

  // configuration privilege may not exceed the writer's own privilege
  // reserved bits masked on entry, so they read zero
  wire [1:0]  cfg_pl_req = i_req_wdata[`CFG_PRIV_LSB+1:`CFG_PRIV_LSB];
  wire [1:0]  cfg_pl_new = (cfg_pl_req < i_cur_priv) ? i_cur_priv : cfg_pl_req;
  wire [63:0] cfg_wr     = (i_req_wdata & `CFG_WRITE_MASK &
                            ~(64'h0000000000000003 << `CFG_PRIV_LSB)) |
                           ({62'h0, cfg_pl_new} << `CFG_PRIV_LSB);

  // legacy flags keep their protected fields outside privilege zero
  // protected bits are a local choice, held in one mask
  wire [63:0] flags_keep = (i_cur_priv != 2'b00) ? `LEG_FLAGS_PRIV_MASK : 64'h0;
  wire [63:0] flags_wr   = (i_req_wdata & ~flags_keep) | (flags_q & flags_keep);

  // one decode gives both array addresses
  wire [3:0]  wslot   = slot_of(i_req_index);
  wire        mem_we  = wr_ok && (wslot != SLOT_NONE);

  // plain registers share one small array to save flops
  app_reg_mem #(
    .WIDTH (64),
    .DEPTH (16),
    .AW    (4)
  ) u_mem (
    .i_sys_clk (i_sys_clk),
    .i_srst    (i_srst),
    .i_we      (mem_we),
    .i_waddr   (wslot),
    .i_wdata   (i_req_wdata),
    .i_raddr   (wslot),
    .o_rdata   (mem_rdata)
  );

  // field decode kept apart so the engine sees named controls
  stack_cfg_decode u_cfg (
    .i_cfg                   (cfg_q),
    .o_eager_load            (o_eager_load),
    .o_eager_store           (o_eager_store),
    .o_stack_privilege_field (o_stack_privilege_field),
    .o_stack_byte_order      (o_stack_byte_order),
    .o_load_distance         (o_load_distance)
  );

  // kernel message registers; legacy side-writes only in legacy mode
  // each slot owns its word so every flop has a single driver;
  // an instruction write beats a legacy write to the same slot
  genvar g;
  generate
    for (g = 0; g < 8; g = g + 1)
    begin : g_kmsg
      reg  [63:0] word_q;
      wire        leg_hit = i_legacy_mode && i_legacy_kmsg_we &&
                            (i_legacy_kmsg_sel == g) && (g < 3);
      always @(posedge i_sys_clk)
      begin
        if (i_srst)
          word_q <= `RESET_WORD;
        else if (wr_ok && kmsg_idx && i_req_index[2:0] == g)
          word_q <= i_req_wdata;
        else if (leg_hit)
          word_q <= i_legacy_kmsg_wdata;
      end
      assign kmsg_all[g*64 +: 64] = word_q;
    end
  endgenerate

  // named flop registers; writes blocked when faulted
  always @(posedge i_sys_clk)
  begin
    if (i_srst)
    begin
      cfg_q       <= `RESET_WORD;
      spill_q     <= `RESET_WORD;
      token_q     <= `RESET_WORD;
      flags_q     <= `RESET_WORD;
      comb_ctrl_q <= `RESET_WORD;
      cmpxchg_q   <= `RESET_WORD;
      loop_q      <= `RESET_WORD;
    end
    else if (wr_ok)
    begin
      case (i_req_index)
        `IDX_STACK_CFG:     cfg_q       <= cfg_wr;
        `IDX_STACK_SPILL:   spill_q     <= i_req_wdata;
        `IDX_STACK_TOKEN:   token_q     <= i_req_wdata & `TOKEN_WRITE_MASK;
        `IDX_LEG_FLAGS:     flags_q     <= flags_wr;
        `IDX_LEG_COMB_CTRL: comb_ctrl_q <= i_req_wdata;
        `IDX_CMPXCHG_VAL:   cmpxchg_q   <= i_req_wdata;
        `IDX_LOOP_COUNTER:  loop_q      <= i_req_wdata;
        default:            cfg_q       <= cfg_q;
      endcase
    end
  end

  // backing pointer follows only the stack engine, never register writes
  // a register write here is answered without fault and dropped
  always @(posedge i_sys_clk)
  begin
    if (i_srst)
      backing_q <= `RESET_WORD;
    else if (i_backing_we)
      backing_q <= i_backing_wdata;
  end

  // timer counts every cycle it is not loaded; an instruction write wins over the engine load
  // limitation: no securing, reads answered at any privilege
  always @(posedge i_sys_clk)
  begin
    if (i_srst)
      timer_q <= `RESET_WORD;
    else if (wr_ok && i_req_index == `IDX_INTERVAL_TIMER)
      timer_q <= i_req_wdata;
    else if (i_timer_we)
      timer_q <= i_timer_wdata;
    else
      timer_q <= timer_q + 64'h0000000000000001;
  end

  // six-bit epilog counter; loop branches may load it from outside
  // an instruction write wins when both fall in one cycle
  always @(posedge i_sys_clk)
  begin
    if (i_srst)
      epilog_q <= {EPILOG_W{1'b0}};
    else if (wr_ok && i_req_index == `IDX_EPILOG_COUNTER)
      epilog_q <= i_req_wdata[EPILOG_W-1:0];
    else if (i_epilog_we)
      epilog_q <= i_epilog_wdata;
  end

  // read data for flop registers captured alongside the storage read
  always @(posedge i_sys_clk)
  begin
    if (i_srst)
    begin
      src_q       <= SRC_ZERO;
      reg_rdata_q <= `RESET_WORD;
    end
    else
    begin
      src_q       <= SRC_ZERO;
      reg_rdata_q <= `RESET_WORD;
      if (i_req_valid && !i_req_write && legal && !ign_idx)
      begin
        if (wslot != SLOT_NONE)
          src_q <= SRC_MEM;
        else
        begin
          src_q <= SRC_REG;
          if (kmsg_idx)
            reg_rdata_q <= kmsg_all[{i_req_index[2:0], 6'h00} +: 64];
          else
          begin
            case (i_req_index)
              `IDX_STACK_CFG:      reg_rdata_q <= cfg_q;
              `IDX_STACK_BACKING:  reg_rdata_q <= backing_q;
              `IDX_STACK_SPILL:    reg_rdata_q <= spill_q;
              `IDX_STACK_TOKEN:    reg_rdata_q <= token_q;
              `IDX_LEG_FLAGS:      reg_rdata_q <= flags_q;
              `IDX_LEG_COMB_CTRL:  reg_rdata_q <= comb_ctrl_q;
              `IDX_CMPXCHG_VAL:    reg_rdata_q <= cmpxchg_q;
              `IDX_INTERVAL_TIMER: reg_rdata_q <= timer_q;
              `IDX_LOOP_COUNTER:   reg_rdata_q <= loop_q;
              `IDX_EPILOG_COUNTER: reg_rdata_q <= {{(64-EPILOG_W){1'b0}}, epilog_q};
              default:             reg_rdata_q <= `RESET_WORD;
            endcase
          end
        end
      end
    end
  end

  // answer one cycle after the request, faults with it
  always @(posedge i_sys_clk)
  begin
    if (i_srst)
    begin
      o_rsp_valid     <= 1'b0;
      o_priv_fault    <= 1'b0;
      o_illegal_fault <= 1'b0;
    end
    else
    begin
      o_rsp_valid     <= i_req_valid;
      o_illegal_fault <= i_req_valid && !legal;
      o_priv_fault    <= i_req_valid && legal && priv_bad;
    end
  end

  // final read mux; ignored indices read zero
  // mux sits after the flops so data lines up with o_rsp_valid
  always @*
  begin
    case (src_q)
      SRC_MEM: o_rsp_rdata = mem_rdata;
      SRC_REG: o_rsp_rdata = reg_rdata_q;
      default: o_rsp_rdata = `RESET_WORD;
    endcase
  end

  assign o_stack_spill_pointer    = spill_q;
  assign o_stack_token_collection = token_q;
  assign o_compare_exchange_value = cmpxchg_q;
  assign o_loop_counter           = loop_q;
  assign o_epilog_counter         = epilog_q;

endmodule

// ---- app_reg_chk.sv ----
// checker on the ports of the application register file
// assumes a bind from the testbench top, one clock, synchronous reset
`timescale 1ns/1ps
module app_reg_chk (
  input wire        i_sys_clk,
  input wire        i_srst,
  input wire        i_req_valid,
  input wire        i_req_write,
  input wire        i_req_unit,
  input wire [6:0]  i_req_index,
  input wire [63:0] i_req_wdata,
  input wire [1:0]  i_cur_priv,
  input wire        o_rsp_valid,
  input wire        o_priv_fault,
  input wire        o_illegal_fault,
  input wire        o_eager_load,
  input wire        o_eager_store,
  input wire [1:0]  o_stack_privilege_field,
  input wire        o_stack_byte_order,
  input wire [13:0] o_load_distance,
  input wire [63:0] o_stack_token_collection
);
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (i_srst);

  // request classes, decoded from the inputs only
  wire wr      = i_req_valid && i_req_write;
  wire cfg_wr  = wr && !i_req_unit && i_req_index == 7'h10;
  wire bad_u   = i_req_unit ? i_req_index < 7'h30
                            : (i_req_index >= 7'h40 && i_req_index < 7'h70);
  wire prot    = i_req_index <= 7'h07 || i_req_index == 7'h1B;
  wire ign     = (i_req_index >= 7'h30 && i_req_index < 7'h40) || i_req_index >= 7'h70;
  reg  [1:0] pl_exp_q;

  // clamp reference kept apart so a flipped compare in the design shows
  always @(posedge i_sys_clk)
    pl_exp_q <= (i_req_wdata[3:2] < i_cur_priv) ? i_cur_priv : i_req_wdata[3:2];

  rsp_timing_a: assert property (i_req_valid |=> o_rsp_valid)
    else $error("response missing one cycle after request");
  rsp_idle_a: assert property (!i_req_valid |=> !o_rsp_valid && !o_illegal_fault)
    else $error("response without request");
  unit_route_a: assert property (i_req_valid && bad_u |=> o_illegal_fault)
    else $error("wrong unit not refused");
  rsvd_index_a: assert property (i_req_valid && i_req_index == 7'h08 |=> o_illegal_fault)
    else $error("reserved index not refused");
  priv_write_a: assert property (wr && !i_req_unit && prot && i_cur_priv != 2'h0
    |=> o_priv_fault && !o_illegal_fault)
    else $error("protected write at low privilege not faulted");
  ignored_idx_a: assert property (i_req_valid && ign |=> !o_illegal_fault && !o_priv_fault)
    else $error("ignored index faulted");
  cfg_priv_a: assert property (cfg_wr |=> o_stack_privilege_field == pl_exp_q)
    else $error("config privilege field not clamped");
  cfg_fields_a: assert property (cfg_wr |=> {o_eager_load, o_eager_store, o_stack_byte_order,
    o_load_distance} == {$past(i_req_wdata[1:0]), $past(i_req_wdata[4]),
    $past(i_req_wdata[29:16])})
    else $error("config fields not driven from written word");
  token_top_a: assert property (o_stack_token_collection[63] == 1'b0)
    else $error("token bit 63 set");

  cover property (cfg_wr);
  cover property (i_req_valid && bad_u);
  cover property (wr && prot && i_cur_priv != 2'h0);
  cover property (i_req_valid && ign);
endmodule

// ---- exec_unit_model.sv ----
// model of the memory and integer execution units issuing register accesses
// assumes a response registered on the taking edge itself, sampled 1 ns after it
`timescale 1ns/1ps
module exec_unit_model (
  input  wire        i_sys_clk,
  input  wire        i_rsp_valid,
  input  wire [63:0] i_rsp_rdata,
  input  wire        i_priv_fault,
  input  wire        i_illegal_fault,
  output reg         o_req_valid,
  output reg         o_req_write,
  output reg         o_req_unit,
  output reg  [6:0]  o_req_index,
  output reg  [63:0] o_req_wdata
);
  reg [63:0] got_rdata;
  reg        got_ok;
  reg        got_priv;
  reg        got_ill;

  // idle request lines at time zero
  initial
  begin
    o_req_valid = 1'b0;
    o_req_write = 1'b0;
    o_req_unit  = 1'b0;
    o_req_index = 7'h00;
    o_req_wdata = 64'h0;
  end

  // one access, held until its taking edge, answer sampled after it
  task access(input w, input u, input [6:0] idx, input [63:0] d);
    begin
      @(posedge i_sys_clk);
      o_req_valid <= 1'b1;
      o_req_write <= w;
      o_req_unit  <= u;
      o_req_index <= idx;
      o_req_wdata <= d;
      @(posedge i_sys_clk);
      o_req_valid <= 1'b0;
      o_req_wdata <= ~d; // released data must not look held
      #1;
      got_ok    = i_rsp_valid;
      got_rdata = i_rsp_rdata;
      got_priv  = i_priv_fault;
      got_ill   = i_illegal_fault;
    end
  endtask
endmodule

// ---- application_register_file_test.sv ----
// self-checking bench for the application register file
// assumes the unit model drives requests, the bench drives side inputs
`timescale 1ns/1ps
module application_register_file_test;
  reg         i_sys_clk = 1'b0;
  reg         i_srst = 1'b1;
  reg  [1:0]  i_cur_priv = 2'h0;
  reg         i_legacy_mode = 1'b0;
  reg         i_legacy_kmsg_we = 1'b0;
  reg  [1:0]  i_legacy_kmsg_sel = 2'h0;
  reg  [63:0] i_legacy_kmsg_wdata = 64'h0;
  reg         i_backing_we = 1'b0;
  reg  [63:0] i_backing_wdata = 64'h0;
  reg         i_timer_we = 1'b0;
  reg  [63:0] i_timer_wdata = 64'h0;
  reg         i_epilog_we = 1'b0;
  reg  [5:0]  i_epilog_wdata = 6'h00;
  wire        i_req_valid, i_req_write, i_req_unit;
  wire [6:0]  i_req_index;
  wire [63:0] i_req_wdata, o_rsp_rdata;
  wire        o_rsp_valid, o_priv_fault, o_illegal_fault;
  wire        o_eager_load, o_eager_store, o_stack_byte_order;
  wire [1:0]  o_stack_privilege_field;
  wire [13:0] o_load_distance;
  wire [63:0] o_stack_spill_pointer, o_stack_token_collection;
  wire [63:0] o_compare_exchange_value, o_loop_counter;
  wire [5:0]  o_epilog_counter;
  integer     num_errors = 0;
  integer     checked = 0;
  integer     m;

  application_register_file uut (.i_sys_clk, .i_srst, .i_req_valid, .i_req_write,
    .i_req_unit, .i_req_index, .i_req_wdata, .i_cur_priv, .i_legacy_mode,
    .i_legacy_kmsg_we, .i_legacy_kmsg_sel, .i_legacy_kmsg_wdata, .i_backing_we,
    .i_backing_wdata, .i_timer_we, .i_timer_wdata, .i_epilog_we, .i_epilog_wdata,
    .o_rsp_valid, .o_rsp_rdata, .o_priv_fault, .o_illegal_fault, .o_eager_load,
    .o_eager_store, .o_stack_privilege_field, .o_stack_byte_order, .o_load_distance,
    .o_stack_spill_pointer, .o_stack_token_collection, .o_compare_exchange_value,
    .o_loop_counter, .o_epilog_counter);

  exec_unit_model u_eu (.i_sys_clk, .i_rsp_valid(o_rsp_valid), .i_rsp_rdata(o_rsp_rdata),
    .i_priv_fault(o_priv_fault), .i_illegal_fault(o_illegal_fault),
    .o_req_valid(i_req_valid), .o_req_write(i_req_write), .o_req_unit(i_req_unit),
    .o_req_index(i_req_index), .o_req_wdata(i_req_wdata));

  // 125 MHz clock
  initial
  begin
    forever #4 i_sys_clk = ~i_sys_clk;
  end

  task chk(input [63:0] got, input [63:0] exp);
    begin
      checked = checked + 1;
      if (got !== exp)
      begin
        num_errors = num_errors + 1;
        $display("[FAIL] %0t got %h expected %h", $time, got, exp);
      end
    end
  endtask

  // access, then compare {valid, priv fault, illegal fault} and read data
  task acc(input w, input u, input [6:0] idx, input [63:0] d, input [1:0] ef,
           input [63:0] ed);
    begin
      u_eu.access(w, u, idx, d);
      chk({61'h0, u_eu.got_ok, u_eu.got_priv, u_eu.got_ill}, {61'h0, 1'b1, ef});
      chk(u_eu.got_rdata, ed);
    end
  endtask

  task set_priv(input [1:0] p);
    begin
      @(posedge i_sys_clk);
      i_cur_priv <= p;
    end
  endtask

  task t_cfg;
    begin
      acc(1, 0, 7'h10, ~64'h0, 2'h0, 64'h0);
      acc(0, 0, 7'h10, 64'h0, 2'h0, 64'h3FFF001F);
      chk({o_stack_privilege_field, o_stack_byte_order, o_load_distance},
          {2'h3, 1'b1, 14'h3FFF});
      for (m = 0; m < 4; m = m + 1)
      begin
        acc(1, 0, 7'h10, m, 2'h0, 64'h0);
        chk({o_eager_load, o_eager_store}, m);
      end
      chk(o_stack_byte_order, 1'b0);
      set_priv(2'h2);
      acc(1, 0, 7'h10, 64'h4, 2'h0, 64'h0);
      chk(o_stack_privilege_field, 2'h2);
      acc(1, 0, 7'h10, 64'h2A5C0000, 2'h0, 64'h0);
      chk(o_load_distance, 14'h2A5C);
      acc(0, 0, 7'h10, 64'h0, 2'h0, 64'h2A5C0008);
    end
  endtask

  task t_kmsg;
    begin
      set_priv(2'h0);
      acc(1, 0, 7'h03, 64'hA5, 2'h0, 64'h0);
      set_priv(2'h1);
      acc(1, 0, 7'h03, 64'h5A, 2'h2, 64'h0);
      acc(1, 0, 7'h1B, 64'h5A, 2'h2, 64'h0);
      acc(0, 0, 7'h03, 64'h0, 2'h0, 64'hA5);
      acc(1, 1, 7'h03, 64'h1, 2'h1, 64'h0);
      set_priv(2'h0);
    end
  endtask

  task t_misc;
    begin
      @(posedge i_sys_clk);
      i_backing_we <= 1'b1;
      i_backing_wdata <= 64'h1234;
      @(posedge i_sys_clk);
      i_backing_we <= 1'b0;
      acc(1, 0, 7'h11, ~64'h0, 2'h0, 64'h0);
      acc(0, 0, 7'h11, 64'h0, 2'h0, 64'h1234);
      acc(1, 0, 7'h13, ~64'h0, 2'h0, 64'h0);
      acc(0, 0, 7'h13, 64'h0, 2'h0, 64'h7FFFFFFFFFFFFFFF);
      acc(1, 1, 7'h42, ~64'h0, 2'h0, 64'h0);
      acc(0, 1, 7'h42, 64'h0, 2'h0, 64'h3F);
      chk(o_epilog_counter, 6'h3F);
      @(posedge i_sys_clk);
      i_epilog_we <= 1'b1;
      i_epilog_wdata <= 6'h15;
      @(posedge i_sys_clk);
      i_epilog_we <= 1'b0;
      acc(0, 1, 7'h42, 64'h0, 2'h0, 64'h15);
      // timer moves one count between the write and the read
      acc(1, 0, 7'h2C, 64'h100, 2'h0, 64'h0);
      acc(0, 0, 7'h2C, 64'h0, 2'h0, 64'h101);
      @(posedge i_sys_clk);
      i_timer_we <= 1'b1;
      i_timer_wdata <= 64'h200;
      @(posedge i_sys_clk);
      i_timer_we <= 1'b0;
      acc(0, 0, 7'h2C, 64'h0, 2'h0, 64'h201);
    end
  endtask

  task t_refuse;
    begin
      acc(1, 0, 7'h20, 64'hC, 2'h0, 64'h0);
      acc(1, 1, 7'h20, 64'h1, 2'h1, 64'h0);
      acc(1, 0, 7'h08, ~64'h0, 2'h1, 64'h0);
      acc(0, 0, 7'h20, 64'h0, 2'h0, 64'hC);
      acc(0, 0, 7'h41, 64'h0, 2'h1, 64'h0);
      acc(1, 0, 7'h32, ~64'h0, 2'h0, 64'h0);
      acc(0, 1, 7'h32, 64'h0, 2'h0, 64'h0);
      acc(0, 0, 7'h78, 64'h0, 2'h0, 64'h0);
    end
  endtask

  task t_legacy;
    begin
      acc(1, 0, 7'h18, ~64'h0, 2'h0, 64'h0);
      set_priv(2'h3);
      acc(1, 0, 7'h18, 64'h0, 2'h0, 64'h0);
      acc(0, 0, 7'h18, 64'h0, 2'h0, 64'h3000);
      set_priv(2'h0);
      i_legacy_mode <= 1'b1;
      i_legacy_kmsg_we <= 1'b1;
      i_legacy_kmsg_sel <= 2'h1;
      i_legacy_kmsg_wdata <= 64'hBEEF;
      @(posedge i_sys_clk);
      i_legacy_kmsg_we <= 1'b0;
      acc(0, 0, 7'h01, 64'h0, 2'h0, 64'hBEEF);
      i_legacy_mode <= 1'b0;
    end
  endtask

  // plain read/write indices, all written before any is read back
  function [6:0] rw_idx(input integer n);
    begin
      case (n)
        0:       rw_idx = 7'h12;
        1:       rw_idx = 7'h15;
        2:       rw_idx = 7'h19;
        3:       rw_idx = 7'h1A;
        4:       rw_idx = 7'h1B;
        5:       rw_idx = 7'h1C;
        6:       rw_idx = 7'h1D;
        7:       rw_idx = 7'h1E;
        8:       rw_idx = 7'h20;
        9:       rw_idx = 7'h24;
        10:      rw_idx = 7'h28;
        11:      rw_idx = 7'h40;
        12:      rw_idx = 7'h41;
        default: rw_idx = 7'h00;
      endcase
    end
  endfunction

  task t_store;
    begin
      for (m = 0; m < 13; m = m + 1)
        acc(1, rw_idx(m) > 7'h3F, rw_idx(m), {57'h1C3, rw_idx(m)}, 2'h0, 64'h0);
      for (m = 0; m < 13; m = m + 1)
        acc(0, rw_idx(m) > 7'h3F, rw_idx(m), 64'h0, 2'h0, {57'h1C3, rw_idx(m)});
      chk(o_stack_spill_pointer, {57'h1C3, 7'h12});
      chk(o_compare_exchange_value, {57'h1C3, 7'h20});
      chk(o_loop_counter, {57'h1C3, 7'h41});
    end
  endtask

  // mid-run reset clears every register and output
  task t_reset;
    begin
      @(posedge i_sys_clk);
      i_srst <= 1'b1;
      @(posedge i_sys_clk);
      i_srst <= 1'b0;
      #1;
      chk(o_stack_spill_pointer | o_loop_counter | o_compare_exchange_value |
          o_stack_token_collection, 64'h0);
      chk({o_eager_load, o_eager_store, o_stack_privilege_field, o_stack_byte_order,
          o_load_distance, o_epilog_counter}, 64'h0);
      acc(0, 0, 7'h12, 64'h0, 2'h0, 64'h0);
    end
  endtask

  task end_of_test;
    begin
      $display("checked %0d errors %0d", checked, num_errors);
      if (num_errors == 0 && checked > 0)
        $display("*** PASS ***");
      else
        $display("*** FAIL ***");
      $finish;
    end
  endtask

  // 63 accesses of two cycles each; far more than needed
  initial
  begin
    #20000;
    num_errors = num_errors + 1;
    end_of_test;
  end

  initial
  begin
    repeat (4) @(posedge i_sys_clk);
    i_srst <= 1'b0;
    t_cfg;
    t_kmsg;
    t_misc;
    t_refuse;
    t_legacy;
    t_store;
    t_reset;
    end_of_test;
  end
endmodule

bind application_register_file app_reg_chk u_chk (.i_sys_clk, .i_srst, .i_req_valid,
  .i_req_write, .i_req_unit, .i_req_index, .i_req_wdata, .i_cur_priv, .o_rsp_valid,
  .o_priv_fault, .o_illegal_fault, .o_eager_load, .o_eager_store,
  .o_stack_privilege_field, .o_stack_byte_order, .o_load_distance,
  .o_stack_token_collection);
